// ==== design/epo_pkg.sv ====
// Shared constants, field layouts and carrier types for the PWM output block.
// Assumes an 8-bit register port with one-cycle read latency and a 10 MHz clock.
package epo_pkg;

  // Block dimensions.
  localparam int NUM_UNITS = 5;
  localparam int NUM_ENH = 3;
  localparam int NUM_TMR = 3;
  localparam int PINS_PER_ENH = 4;
  localparam int NUM_PINS = 14;
  localparam int STD_PIN_BASE = 12;

  // Register indices on the 8-bit register port.
  localparam logic [7:0] ADDR_CTL_BASE = 8'h00;
  localparam logic [7:0] ADDR_DUTY_BASE = 8'h05;
  localparam logic [7:0] ADDR_BUF_BASE = 8'h0A;
  localparam logic [7:0] ADDR_TSEL0 = 8'h10;
  localparam logic [7:0] ADDR_TSEL1 = 8'h11;
  localparam logic [7:0] ADDR_PER_BASE = 8'h12;
  localparam logic [7:0] ADDR_TCTL_BASE = 8'h15;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h18;
  localparam logic [7:0] ADDR_SHD_BASE = 8'h20;
  localparam logic [7:0] ADDR_DBD_BASE = 8'h23;
  localparam logic [7:0] ADDR_STR_BASE = 8'h26;
  localparam logic [7:0] ADDR_DIR_LO = 8'h30;
  localparam logic [7:0] ADDR_DIR_HI = 8'h31;
  localparam logic [7:0] ADDR_LAT_LO = 8'h32;
  localparam logic [7:0] ADDR_LAT_HI = 8'h33;

  // Implemented-bit masks; cleared positions always read as zero.
  localparam logic [7:0] MASK_CTL_ENH = 8'hFF;
  localparam logic [7:0] MASK_CTL_STD = 8'h3F;
  localparam logic [7:0] MASK_TSEL0 = 8'hDB;
  localparam logic [7:0] MASK_TSEL1 = 8'h0F;
  localparam logic [7:0] MASK_TCTL = 8'h7F;
  localparam logic [7:0] MASK_STR = 8'h0F;
  localparam logic [7:0] MASK_PIN_HI = 8'h3F;

  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_STEER = 8'h01;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [9:0] RST_DUTY10 = 10'h000;

  // Unit control field positions.
  localparam int MODE_LSB = 0;
  localparam int DLOW_LSB = 4;
  localparam int ARR_LSB = 6;
  localparam int POL_AC_BIT = 1;
  localparam int POL_BD_BIT = 0;
  localparam logic [1:0] MODE_PWM_TAG = 2'h3;

  // Timer control field positions and prescale codes.
  localparam int TCTL_RUN_BIT = 2;
  localparam int TCTL_PS_LSB = 0;
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [5:0] SUB_LAST1 = 6'h03;
  localparam logic [5:0] SUB_LAST4 = 6'h0F;
  localparam logic [5:0] SUB_LAST16 = 6'h3F;

  // Timer-select field positions, one per unit.
  localparam int TSEL_LSB [NUM_UNITS] = '{0, 3, 6, 0, 2};

  // Clock rate; the timers step from it directly.
  localparam int CLK_HZ = 10_000_000;

  // Output arrangement codes.
  typedef enum logic [1:0] {
    ARR_SINGLE = 2'b00,
    ARR_FULL_FWD = 2'b01,
    ARR_HALF = 2'b10,
    ARR_FULL_REV = 2'b11
  } epo_arr_type;

  // Per-unit start sequencing.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } epo_state_type;

  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } epo_bus_req_type;

  // Period timer configuration.
  typedef struct packed {
    logic run;
    logic [1:0] ps;
    logic [7:0] period;
  } epo_tmr_cfg_type;

  // Pin drive bundle.
  typedef struct packed {
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] oe;
  } epo_pins_type;

endpackage

// ==== design/epo_timer.sv ====
// One 8-bit period timer with prescaler and the two extra time-base bits.
// Assumes the caller holds its configuration and count-write strobe in clk domain.
`timescale 1ns/1ps
module epo_timer
  import epo_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Configuration and software count write.
  input wire epo_tmr_cfg_type cfg,
  input wire logic cnt_wr,
  input wire logic [7:0] cnt_wdata,
  // Time base.
  output logic [7:0] count,
  output logic [1:0] tb_low,
  output logic roll
);

  logic [5:0] sub_reg;
  logic [7:0] count_reg;
  logic [5:0] sub_last;
  logic step;

  // Prescale picks both the step rate and which sub-count bits extend the count.
  always_comb begin
    case (cfg.ps)
      PS_DIV1: begin
        sub_last = SUB_LAST1;
        tb_low = sub_reg[1:0];
      end
      PS_DIV4: begin
        sub_last = SUB_LAST4;
        tb_low = sub_reg[3:2];
      end
      default: begin
        sub_last = SUB_LAST16;
        tb_low = sub_reg[5:4];
      end
    endcase
  end

  // The count steps every four clocks times the prescale, straight off clk. R1
  assign step = cfg.run && (sub_reg == sub_last);
  assign roll = step && (count_reg == cfg.period);
  assign count = count_reg;

  // Sub-count holds while stopped so the time base resumes where it left off.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sub_reg <= 6'h00;
    end else if (cfg.run) begin
      sub_reg <= step ? 6'h00 : sub_reg + 6'h01;
    end
  end

  // Software writes win over the timer's own step.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= RST_ZERO;
    end else if (cnt_wr) begin
      count_reg <= cnt_wdata;
    end else if (roll) begin
      count_reg <= RST_ZERO; // R15
    end else if (step) begin
      count_reg <= count_reg + 8'h01;
    end
  end

endmodule

// ==== design/epo_pwm_top.sv ====
// Five PWM units over three period timers, with pin muxing and a register port.
// Assumes a same-clock register master: one-cycle strobes, read data one cycle later.
`timescale 1ns/1ps
// What this block does
// [R1] Timers step straight from the system clock, so output frequency follows it.
// [R2] Reset sets every pin to input and every register to its reset value.
// [R3] Units one to three are enhanced; units four and five are single-output only.
// [R4] Enhanced units drive up to four pins with ten-bit duty resolution.
// [R5] Period, timer control, timer select, duty byte and unit control shape the waveform.
// [R6] Enhanced units carry shutdown, dead-band and steering registers.
// [R7] The two-bit arrangement field picks one of four output arrangements.
// [R8] Pins follow the port latch except where the arrangement uses them.
// [R9] The four-bit mode field sets active polarity of each pin pair.
// [R10] Software clears a pin's direction bit before the pin is driven.
// [R11] Writing zero to unit control releases its pins.
// [R12] Pins unused by the arrangement stay free for other functions.
// [R13] After enabling, outputs wait for a new period so no pulse is cut.
// [R14] Unimplemented register bits read as zero.
// [R15] On period roll: clear count, set output unless duty zero, latch duty.
// [R16] Output clears when the ten-bit time base equals the buffered duty.
// [R17] Half-bridge drives A with the signal and B with its complement.
// [R18] Full-bridge forward holds A active, modulates D, holds B and C inactive.
// [R19] Each unit uses only the timer its two-bit select field names, and the first timer for code three.
// [R20] Duty low bits from unit control join below the duty byte.
module epo_pwm_top
  import epo_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire epo_bus_req_type bus,
  output logic [7:0] rd_data,
  // Pins.
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_pwm_owned
);

  // Register read views gathered from the generate blocks.
  logic [NUM_UNITS-1:0][7:0] ctl_rd;
  logic [NUM_UNITS-1:0][7:0] duty_rd;
  logic [NUM_UNITS-1:0][9:0] buf_rd;
  logic [NUM_ENH-1:0][7:0] shd_rd;
  logic [NUM_ENH-1:0][7:0] dbd_rd;
  logic [NUM_ENH-1:0][7:0] str_rd;
  logic [NUM_TMR-1:0][7:0] per_rd;
  logic [NUM_TMR-1:0][7:0] tctl_rd;
  logic [NUM_TMR-1:0][7:0] cnt_rd;
  logic [NUM_TMR-1:0][1:0] tb_low;
  logic [NUM_TMR-1:0] roll;

  logic [7:0] tsel0_reg;
  logic [7:0] tsel1_reg;
  logic [15:0] dir_reg;
  logic [15:0] lat_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_next;
  epo_pins_type pins_next;
  epo_pins_type pins_reg;
  logic [NUM_PINS-1:0] own_next;
  logic [NUM_PINS-1:0] own_reg;

  // Timer-select and pin registers; reserved bits are masked on the way in.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tsel0_reg <= RST_ZERO; // R2
      tsel1_reg <= RST_ZERO;
      dir_reg <= {RST_DIR & MASK_PIN_HI, RST_DIR};
      lat_reg <= {RST_ZERO, RST_ZERO};
    end else if (bus.wr) begin
      if (bus.addr == ADDR_TSEL0) begin
        tsel0_reg <= bus.wdata & MASK_TSEL0; // R14
      end else if (bus.addr == ADDR_TSEL1) begin
        tsel1_reg <= bus.wdata & MASK_TSEL1; // R14
      end else if (bus.addr == ADDR_DIR_LO) begin
        dir_reg[7:0] <= bus.wdata;
      end else if (bus.addr == ADDR_DIR_HI) begin
        dir_reg[15:8] <= bus.wdata & MASK_PIN_HI;
      end else if (bus.addr == ADDR_LAT_LO) begin
        lat_reg[7:0] <= bus.wdata;
      end else if (bus.addr == ADDR_LAT_HI) begin
        lat_reg[15:8] <= bus.wdata & MASK_PIN_HI;
      end
    end
  end

  // Period timers with their period and control registers.
  generate
    for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
      localparam logic [7:0] A_PER = ADDR_PER_BASE + 8'(t);
      localparam logic [7:0] A_TCTL = ADDR_TCTL_BASE + 8'(t);
      localparam logic [7:0] A_CNT = ADDR_CNT_BASE + 8'(t);
      logic [7:0] per_reg;
      logic [7:0] tctl_reg;
      epo_tmr_cfg_type cfg;

      // Postscale bits are stored only; they never shape the period.
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          per_reg <= RST_PERIOD; // R2
          tctl_reg <= RST_ZERO;
        end else if (bus.wr && bus.addr == A_PER) begin
          per_reg <= bus.wdata; // R5
        end else if (bus.wr && bus.addr == A_TCTL) begin
          tctl_reg <= bus.wdata & MASK_TCTL; // R14
        end
      end

      assign cfg.run = tctl_reg[TCTL_RUN_BIT];
      assign cfg.ps = tctl_reg[TCTL_PS_LSB +: 2];
      assign cfg.period = per_reg;
      assign per_rd[t] = per_reg;
      assign tctl_rd[t] = tctl_reg;

      epo_timer u_tmr (
        .clk(clk),
        .nrst(nrst),
        .cfg(cfg),
        .cnt_wr(bus.wr && bus.addr == A_CNT),
        .cnt_wdata(bus.wdata),
        .count(cnt_rd[t]),
        .tb_low(tb_low[t]),
        .roll(roll[t])
      );
    end
  endgenerate

  // One PWM unit per entry; the first three carry the bridge logic.
  generate
    for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
      localparam bit ENH = (i < NUM_ENH); // R3
      localparam logic [7:0] A_CTL = ADDR_CTL_BASE + 8'(i);
      localparam logic [7:0] A_DUTY = ADDR_DUTY_BASE + 8'(i);
      localparam logic [7:0] MASK_CTL = ENH ? MASK_CTL_ENH : MASK_CTL_STD;
      logic [7:0] ctl_reg;
      logic [7:0] duty_reg;
      logic [9:0] buf_reg;
      logic pwm_reg;
      epo_state_type state_reg;
      logic [1:0] sel;
      logic [7:0] u_cnt;
      logic [1:0] u_low;
      logic u_roll;
      logic [9:0] duty_full;
      logic pwm_mode;
      logic running;
      logic pwm_on;
      logic mod;

      // Timer select code three has no timer behind it and falls back to the first.
      assign sel = ENH ? tsel0_reg[TSEL_LSB[i] +: 2] : tsel1_reg[TSEL_LSB[i] +: 2];
      always_comb begin
        case (sel)
          2'h1: begin
            u_cnt = cnt_rd[1];
            u_low = tb_low[1];
            u_roll = roll[1];
          end
          2'h2: begin
            u_cnt = cnt_rd[2];
            u_low = tb_low[2];
            u_roll = roll[2];
          end
          default: begin
            u_cnt = cnt_rd[0];
            u_low = tb_low[0];
            u_roll = roll[0];
          end
        endcase
      end // R19

      assign duty_full = {duty_reg, ctl_reg[DLOW_LSB +: 2]}; // R20
      assign pwm_mode = (ctl_reg[MODE_LSB + 2 +: 2] == MODE_PWM_TAG);

      // Control and duty byte are writable at any time; the buffer shields the output.
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ctl_reg <= RST_ZERO; // R2
          duty_reg <= RST_ZERO;
        end else if (bus.wr && bus.addr == A_CTL) begin
          ctl_reg <= bus.wdata & MASK_CTL; // R14
        end else if (bus.wr && bus.addr == A_DUTY) begin
          duty_reg <= bus.wdata; // R5
        end
      end

      // Double-buffered duty and the raw modulated level.
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          buf_reg <= RST_DUTY10;
          pwm_reg <= 1'b0;
        end else if (u_roll) begin
          buf_reg <= duty_full; // R15
          pwm_reg <= (duty_full != RST_DUTY10); // R15
        end else if ({u_cnt, u_low} == buf_reg) begin
          pwm_reg <= 1'b0; // R16
        end
      end

      // Enabling arms the unit; it starts only at the next roll of its timer.
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          state_reg <= ST_IDLE;
        end else begin
          case (state_reg)
            ST_IDLE: begin
              if (pwm_mode) begin
                state_reg <= ST_WAIT;
              end
            end
            ST_WAIT: begin
              if (!pwm_mode) begin
                state_reg <= ST_IDLE;
              end else if (u_roll) begin
                state_reg <= ST_RUN; // R13
              end
            end
            ST_RUN: begin
              if (!pwm_mode) begin
                state_reg <= ST_IDLE; // R11
              end
            end
            default: state_reg <= ST_IDLE;
          endcase
        end
      end

      assign running = (state_reg == ST_RUN);
      // The match masks the level at once, so the pulse lasts exactly the duty count.
      assign pwm_on = pwm_reg && ({u_cnt, u_low} != buf_reg); // R16
      assign mod = running && pwm_on; // R13
      assign ctl_rd[i] = ctl_reg;
      assign duty_rd[i] = duty_reg;
      assign buf_rd[i] = buf_reg;

      if (ENH) begin : g_enh
        localparam logic [7:0] A_SHD = ADDR_SHD_BASE + 8'(i);
        localparam logic [7:0] A_DBD = ADDR_DBD_BASE + 8'(i);
        localparam logic [7:0] A_STR = ADDR_STR_BASE + 8'(i);
        logic [7:0] shd_reg;
        logic [7:0] dbd_reg;
        logic [7:0] str_reg;
        logic [3:0] act; // R4
        logic [3:0] used;
        logic [3:0] pol;

        // Shutdown and dead-band settings are held for software only.
        always_ff @(posedge clk or negedge nrst) begin
          if (!nrst) begin
            shd_reg <= RST_ZERO; // R6
            dbd_reg <= RST_ZERO;
            str_reg <= RST_STEER;
          end else if (bus.wr && bus.addr == A_SHD) begin
            shd_reg <= bus.wdata; // R6
          end else if (bus.wr && bus.addr == A_DBD) begin
            dbd_reg <= bus.wdata;
          end else if (bus.wr && bus.addr == A_STR) begin
            str_reg <= bus.wdata & MASK_STR; // R14
          end
        end

        // Bit order is D, C, B, A; act is the active-high meaning of each pin.
        always_comb begin
          case (epo_arr_type'(ctl_reg[ARR_LSB +: 2]))
            ARR_HALF: begin
              act = {2'b00, running && !pwm_on, mod}; // R17
              used = 4'b0011;
            end
            ARR_FULL_FWD: begin
              act = {mod, 1'b0, 1'b0, running}; // R18
              used = 4'b1111;
            end
            ARR_FULL_REV: begin
              act = {1'b0, running, mod, 1'b0};
              used = 4'b1111;
            end
            default: begin
              act = {4{mod}} & str_reg[3:0]; // R7
              used = str_reg[3:0];
            end
          endcase
        end // R7

        // Mode bits pick active-low per pin pair, A with C and B with D.
        assign pol = {ctl_reg[MODE_LSB + POL_BD_BIT], ctl_reg[MODE_LSB + POL_AC_BIT],
                      ctl_reg[MODE_LSB + POL_BD_BIT], ctl_reg[MODE_LSB + POL_AC_BIT]};
        assign pins_next.level[i*PINS_PER_ENH +: PINS_PER_ENH] = act ^ pol; // R9
        assign own_next[i*PINS_PER_ENH +: PINS_PER_ENH] = used & {4{pwm_mode}}; // R12
        assign shd_rd[i] = shd_reg;
        assign dbd_rd[i] = dbd_reg;
        assign str_rd[i] = str_reg;
      end else begin : g_std
        assign pins_next.level[STD_PIN_BASE + i - NUM_ENH] = mod;
        assign own_next[STD_PIN_BASE + i - NUM_ENH] = pwm_mode; // R11
      end
    end
  endgenerate

  // A pin drives only while its direction bit is clear. R10
  assign pins_next.oe = ~dir_reg[NUM_PINS-1:0];

  // Pins not owned by a unit fall back to the port latch.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins_reg <= '0; // R2
      own_reg <= '0;
    end else begin
      pins_reg.level <= (own_next & pins_next.level) | (~own_next & lat_reg[NUM_PINS-1:0]); // R8
      pins_reg.oe <= pins_next.oe;
      own_reg <= own_next; // R12
    end
  end

  assign pin_out = pins_reg.level;
  assign pin_oe = pins_reg.oe;
  assign pin_pwm_owned = own_reg;

  // Read decode; anything unmapped answers zero.
  always_comb begin
    rd_next = RST_ZERO;
    for (int k = 0; k < NUM_UNITS; k++) begin
      if (bus.addr == ADDR_CTL_BASE + 8'(k)) begin
        rd_next = ctl_rd[k];
      end else if (bus.addr == ADDR_DUTY_BASE + 8'(k)) begin
        rd_next = duty_rd[k];
      end else if (bus.addr == ADDR_BUF_BASE + 8'(k)) begin
        rd_next = buf_rd[k][9:2];
      end
    end
    for (int k = 0; k < NUM_TMR; k++) begin
      if (bus.addr == ADDR_PER_BASE + 8'(k)) begin
        rd_next = per_rd[k];
      end else if (bus.addr == ADDR_TCTL_BASE + 8'(k)) begin
        rd_next = tctl_rd[k];
      end else if (bus.addr == ADDR_CNT_BASE + 8'(k)) begin
        rd_next = cnt_rd[k];
      end else if (bus.addr == ADDR_SHD_BASE + 8'(k)) begin
        rd_next = shd_rd[k];
      end else if (bus.addr == ADDR_DBD_BASE + 8'(k)) begin
        rd_next = dbd_rd[k];
      end else if (bus.addr == ADDR_STR_BASE + 8'(k)) begin
        rd_next = str_rd[k];
      end
    end
    if (bus.addr == ADDR_TSEL0) begin
      rd_next = tsel0_reg;
    end else if (bus.addr == ADDR_TSEL1) begin
      rd_next = tsel1_reg;
    end else if (bus.addr == ADDR_DIR_LO) begin
      rd_next = dir_reg[7:0];
    end else if (bus.addr == ADDR_DIR_HI) begin
      rd_next = dir_reg[15:8];
    end else if (bus.addr == ADDR_LAT_LO) begin
      rd_next = lat_reg[7:0];
    end else if (bus.addr == ADDR_LAT_HI) begin
      rd_next = lat_reg[15:8];
    end
  end

  // Read data stand only in the cycle after the strobe; otherwise zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_reg <= RST_ZERO;
    end else begin
      rd_data_reg <= bus.rd ? rd_next : RST_ZERO; // R14
    end
  end

  assign rd_data = rd_data_reg;

endmodule

// ==== test/epo_pwm_checker.sv ====
// Assertions on the PWM block's register port and pins.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module epo_pwm_checker
  import epo_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire epo_bus_req_type bus,
  input wire logic [7:0] rd_data,
  // Pins.
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] pin_pwm_owned
);
  logic [7:0] ctl1_reg;
  logic [2:0] age_reg;
  logic steady;

  // Shadow unit one control, so arrangement rules can be judged at the pins.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl1_reg <= 8'h00;
      age_reg <= 3'h0;
    end else if (bus.wr && bus.addr == ADDR_CTL_BASE) begin
      ctl1_reg <= bus.wdata;
      age_reg <= 3'h0;
    end else if (age_reg != 3'h7) begin
      age_reg <= age_reg + 3'h1;
    end
  end

  // Pins lag a control write by two flops, so judge only once that has settled.
  assign steady = age_reg >= 3'h3;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_rd_idle_zero: assert property (!$past(bus.rd) |-> rd_data == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (bus.rd && bus.addr == 8'h3F |=> rd_data == 8'h00)
    else $error("unmapped read returned nonzero data");
  a_dir_to_oe: assert property (bus.wr && bus.addr == ADDR_DIR_LO |->
    ##2 pin_oe[7:0] == ~$past(bus.wdata, 2))
    else $error("pin enable does not follow direction write");
  a_reset_input: assert property (disable iff (1'b0) !nrst |->
    pin_oe == '0 && pin_pwm_owned == '0)
    else $error("pins not released to input during reset");
  a_zero_release: assert property (bus.wr && bus.addr == ADDR_CTL_BASE &&
    bus.wdata == 8'h00 |-> ##[1:3] pin_pwm_owned[3:0] == 4'h0)
    else $error("cleared control still owns pins");
  a_idle_no_pins: assert property (steady && ctl1_reg[3:2] != MODE_PWM_TAG |->
    pin_pwm_owned[3:0] == 4'h0)
    else $error("unit outside modulation mode owns pins");
  a_single_owns_a: assert property (steady && ctl1_reg == 8'h0C |->
    pin_pwm_owned[3:0] == 4'h1)
    else $error("single arrangement owns wrong pins");
  a_half_compl: assert property (steady && ctl1_reg == 8'h8C &&
    ($rose(pin_out[0]) || $fell(pin_out[0])) |-> pin_out[1] == !pin_out[0])
    else $error("half bridge outputs not complementary");
  a_fwd_inactive: assert property (steady && ctl1_reg == 8'h4C |->
    pin_out[2:1] == 2'b00)
    else $error("forward bridge b or c not inactive");

  c_half_edge: cover property (steady && ctl1_reg == 8'h8C && $rose(pin_out[0]));
  c_fwd_owned: cover property (steady && ctl1_reg == 8'h4C && pin_pwm_owned[3:0] == 4'hF);
  c_unmapped: cover property (bus.rd && bus.addr == 8'h3F);
endmodule

// ==== test/epo_switch_model.sv ====
// Switch driver model on one PWM pin: measures high time and period.
// Assumes a pull-down on its input, so an undriven pin reads low.
`timescale 1ns/1ps
module epo_switch_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Pin as driven by the block.
  input wire logic level,
  input wire logic drive,
  // Measurements in clocks.
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] rises
);
  logic seen;
  logic last;
  logic [15:0] run;

  // The driver sees the level only once the pin is an output.
  assign seen = drive ? level : 1'b0;

  // Time each edge against the last rise.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last <= 1'b0;
      run <= 16'h0;
      hi_len <= 16'h0;
      per_len <= 16'h0;
      rises <= 16'h0;
    end else begin
      last <= seen;
      run <= (seen && !last) ? 16'h1 : run + 16'h1;
      if (seen && !last) begin
        rises <= rises + 16'h1;
        per_len <= run;
      end
      if (!seen && last) begin
        hi_len <= run;
      end
    end
  end
endmodule

// ==== test/enhanced_pwm_output_control_test.sv ====
// Self-checking test of the PWM block through its register port and pins.
// Assumes the design package and a switch model on unit one's pin a.
`timescale 1ns/1ps
module enhanced_pwm_output_control_test;
  import epo_pkg::*;
  logic clk;
  logic nrst = 1'b1;
  epo_bus_req_type bus;
  logic [7:0] rd_data;
  logic [NUM_PINS-1:0] pin_out;
  logic [NUM_PINS-1:0] pin_oe;
  logic [NUM_PINS-1:0] pin_pwm_owned;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  logic [15:0] rises;
  logic [15:0] r0;
  int n_mismatch = 0;
  int n_compared = 0;
  int i;
  logic [7:0] ra [9] = '{8'h12, 8'h26, 8'h30, 8'h31, 8'h00, 8'h15, 8'h0A, 8'h20, 8'h23};
  logic [7:0] rv [9] = '{8'hFF, 8'h01, 8'hFF, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [1:0] arr [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
  logic [3:0] own [4] = '{4'h1, 4'h3, 4'hF, 4'hF};

  epo_pwm_top u_dut (.clk(clk), .nrst(nrst), .bus(bus), .rd_data(rd_data),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pwm_owned(pin_pwm_owned));
  epo_switch_model u_sw (.clk(clk), .nrst(nrst), .level(pin_out[0]), .drive(pin_oe[0]),
    .hi_len(hi_len), .per_len(per_len), .rises(rises));

  // 10 MHz clock.
  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    chk($sformatf("register %h", a), {8'h00, e}, {8'h00, rd_data});
  endtask

  task automatic wait_rises(input int n);
    r0 = rises;
    for (int k = 0; k < 300 && rises != r0 + 16'(n); k++) @(posedge clk);
    #1;
    chk("pulse count", r0 + 16'(n), rises);
  endtask

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    bus = '0;
    // A real falling edge after time zero, so every flop is reset before the first clock.
    #1;
    nrst = 1'b0;
    repeat (20) @(posedge clk);
    chk("oe in reset", 16'h0, {2'b00, pin_oe});
    nrst <= 1'b1;
    for (i = 0; i < 9; i++) rd(ra[i], rv[i]);
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h3F);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'hDB);
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'h7F);
    rd(8'h3F, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h04, 8'h0C);
    // Duty 9 of a 16-clock period on timer a.
    wr(8'h12, 8'h03);
    wr(8'h05, 8'h02);
    wr(8'h30, 8'h00);
    wr(8'h00, 8'h1C);
    wr(8'h15, 8'h04);
    wait_rises(2);
    chk("first high time", 16'd9, hi_len);
    chk("period", 16'd16, per_len);
    rd(8'h0A, 8'h02);
    chk("pin enable", 16'h00FF, {8'h00, pin_oe[7:0]});
    wr(8'h00, 8'h1E);
    wait_rises(3);
    chk("inverted high time", 16'd7, hi_len);
    // Move unit one to timer b with an 8-clock period.
    wr(8'h05, 8'h01);
    wr(8'h00, 8'h0C);
    wr(8'h13, 8'h01);
    wr(8'h16, 8'h04);
    wr(8'h10, 8'h01);
    wait_rises(3);
    chk("timer b period", 16'd8, per_len);
    chk("timer b high", 16'd4, hi_len);
    wr(8'h05, 8'h00);
    repeat (20) @(posedge clk);
    r0 = rises;
    repeat (30) @(posedge clk);
    chk("zero duty pulses", r0, rises);
    chk("zero duty level", 16'h0, {15'h0, pin_out[0]});
    wr(8'h05, 8'h01);
    for (i = 0; i < 4; i++) begin
      wr(8'h00, {arr[i], 6'h0C});
      repeat (30) @(posedge clk);
      chk("owned pins", {12'h0, own[i]}, {12'h0, pin_pwm_owned[3:0]});
      if (i == 2) chk("forward a", 16'h1, {15'h0, pin_out[0]});
      if (i == 3) chk("reverse c", 16'h1, {15'h0, pin_out[2]});
    end
    wr(8'h32, 8'h05);
    wr(8'h00, 8'h00);
    repeat (4) @(posedge clk);
    chk("released level", 16'h5, {12'h0, pin_out[3:0]});
    chk("released owner", 16'h0, {12'h0, pin_pwm_owned[3:0]});
    chk("standard units", 16'h3, {14'h0, pin_pwm_owned[13:12]});
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("oe in reset", 16'h0, {2'b00, pin_oe});
    nrst <= 1'b1;
    rd(8'h04, 8'h00);
    end_sim();
  end

  // Watchdog: the sequence needs about four hundred clocks.
  initial begin
    #(100 * 4000);
    n_mismatch++;
    end_sim();
  end
endmodule

bind epo_pwm_top epo_pwm_checker u_chk (.clk(clk), .nrst(nrst), .bus(bus), .rd_data(rd_data),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pwm_owned(pin_pwm_owned));
